// ==== inc/dppi_pkg.sv ====
// constants and helpers shared by both ends of the dual-block port bus
package dppi_pkg;
	localparam int DATA_W = 8;
	localparam int NUM_BLOCKS = 2;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] SEL_PA   = 2'h0;
	localparam logic [1:0] SEL_PB   = 2'h1;
	localparam logic [1:0] SEL_PC   = 2'h2;
	localparam logic [1:0] SEL_CTRL = 2'h3;
	localparam int MODE_FLAG_BIT = 7;
	localparam int DIR_A_BIT     = 4;
	localparam int DIR_CU_BIT    = 3;
	localparam int DIR_B_BIT     = 1;
	localparam int DIR_CL_BIT    = 0;
	localparam int BSR_VAL_BIT   = 0;
	localparam int BSR_IDX_LSB   = 1;
	localparam int BSR_IDX_W     = 3;
	localparam logic [7:0] CTRL_ALL_IN  = 8'h9B;
	localparam logic [7:0] CTRL_ALL_OUT = 8'h80;
	localparam logic [7:0] CTRL_KEEP    = 8'h9B;
	localparam logic [7:0] LATCH_RESET  = 8'h00;
	localparam logic [7:0] BUS_IDLE     = 8'hFF;
	localparam int SETUP_CYC  = 2;
	localparam int STROBE_CYC = 8;
	localparam int HOLD_CYC   = 2;

	// drive enables for port C: upper and lower nibble follow own bits
	function automatic logic [7:0] pc_drive(input logic [7:0] ctrl);
		pc_drive = {{4{~ctrl[DIR_CU_BIT]}}, {4{~ctrl[DIR_CL_BIT]}}};
	endfunction
endpackage

// ==== inc/dppi_if.sv ====
// pin bundle between host processor end and the dual-block device end
interface dppi_if;
	import dppi_pkg::*;
	logic              block0_select_n;
	logic              block1_select_n;
	logic              port_selector_lsb;
	logic              port_selector_msb;
	logic              read_n;
	logic              write_n;
	logic              rw_dir;
	logic [DATA_W-1:0] host_data;
	logic              host_data_oe;
	logic [DATA_W-1:0] dev_data;
	logic              dev_data_oe;
	logic [DATA_W-1:0] data_bus;

	// idle bus reads as pulled high
	assign data_bus = dev_data_oe ? dev_data :
		(host_data_oe ? host_data : BUS_IDLE);

	modport host (
		output block0_select_n, block1_select_n,
		output port_selector_lsb, port_selector_msb,
		output read_n, write_n, rw_dir, host_data, host_data_oe,
		input  data_bus
	);
	modport device (
		input  block0_select_n, block1_select_n,
		input  port_selector_lsb, port_selector_msb,
		input  read_n, write_n, rw_dir, data_bus,
		output dev_data, dev_data_oe
	);
endinterface

// ==== logic/dppi_block.sv ====
// one port block: control word, three port latches, read mux
module dppi_block
	import dppi_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              strap_s,
	input  wire logic              wr_pulse,
	input  wire logic [1:0]        wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [1:0]        rd_addr,
	input  wire logic [DATA_W-1:0] pa_in,
	input  wire logic [DATA_W-1:0] pb_in,
	input  wire logic [DATA_W-1:0] pc_in,
	output logic      [DATA_W-1:0] rdata,
	output logic      [DATA_W-1:0] pa_out,
	output logic      [DATA_W-1:0] pa_oe,
	output logic      [DATA_W-1:0] pb_out,
	output logic      [DATA_W-1:0] pb_oe,
	output logic      [DATA_W-1:0] pc_out,
	output logic      [DATA_W-1:0] pc_oe
);
	logic [7:0] ctrl_r;
	logic [7:0] pa_r;
	logic [7:0] pb_r;
	logic [7:0] pc_r;
	logic       mode_wr;

	assign mode_wr = wr_pulse && wr_addr == SEL_CTRL
		&& wr_data[MODE_FLAG_BIT];

	// strap high keeps only direction bits, strap low forces all-out on any write; mode fields forced to basic mode
	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_r <= strap_s ? CTRL_ALL_IN : CTRL_ALL_OUT;
		else if (wr_pulse && !strap_s)
			ctrl_r <= CTRL_ALL_OUT;
		else if (mode_wr)
			ctrl_r <= (wr_data & CTRL_KEEP) | CTRL_ALL_OUT;
	end

	always_ff @(posedge clk)
	begin
		if (reset || (wr_pulse && !strap_s) || mode_wr)
		begin
			pa_r <= LATCH_RESET;
			pb_r <= LATCH_RESET;
			pc_r <= LATCH_RESET;
		end
		else if (wr_pulse)
		begin
			case (wr_addr)
				SEL_PA: pa_r <= wr_data;
				SEL_PB: pb_r <= wr_data;
				SEL_PC: pc_r <= wr_data;
				// bit set/reset of port C
				default: pc_r[wr_data[BSR_IDX_LSB +: BSR_IDX_W]] <=
					wr_data[BSR_VAL_BIT];
			endcase
		end
	end

	assign pa_out = pa_r;
	assign pb_out = pb_r;
	assign pc_out = pc_r;
	assign pa_oe  = {DATA_W{~ctrl_r[DIR_A_BIT]}};
	assign pb_oe  = {DATA_W{~ctrl_r[DIR_B_BIT]}};
	assign pc_oe  = pc_drive(ctrl_r);

	// outputs read back their latch, inputs the pin
	always_comb
	begin
		case (rd_addr)
			SEL_PA: rdata = (pa_in & ~pa_oe) | (pa_r & pa_oe);
			SEL_PB: rdata = (pb_in & ~pb_oe) | (pb_r & pb_oe);
			SEL_PC: rdata = (pc_in & ~pc_oe) | (pc_r & pc_oe);
			default: rdata = BUS_IDLE;
		endcase
	end
endmodule

// ==== logic/dppi_device.sv ====
// device end: pin synchronisers, strobe decode, two port blocks
module dppi_device
	import dppi_pkg::*;
#(
	parameter bit SEPARATE_STROBES = 1'b1
)
(
	input  wire logic                              clk,
	input  wire logic                              reset,
	dppi_if.device                                 bus,
	input  wire logic                              block0_reset_state_strap,
	input  wire logic                              block1_reset_state_strap,
	input  wire logic [NUM_BLOCKS-1:0][DATA_W-1:0] pa_in,
	input  wire logic [NUM_BLOCKS-1:0][DATA_W-1:0] pb_in,
	input  wire logic [NUM_BLOCKS-1:0][DATA_W-1:0] pc_in,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pa_out,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pa_oe,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pb_out,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pb_oe,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pc_out,
	output logic      [NUM_BLOCKS-1:0][DATA_W-1:0] pc_oe
);
	localparam int CTL_W = 7;
	localparam int PIN_W = NUM_BLOCKS * DATA_W;

	// control pins, packed for one synchroniser
	logic [CTL_W-1:0] ctl_raw;
	logic [CTL_W-1:0] ctl_s1;
	logic [CTL_W-1:0] ctl_s2;
	logic [DATA_W-1:0] data_s1;
	logic [DATA_W-1:0] data_s2;
	logic [NUM_BLOCKS-1:0] strap_raw;
	logic [NUM_BLOCKS-1:0] strap_s1;
	logic [NUM_BLOCKS-1:0] strap_s2;
	logic [PIN_W-1:0] pa_s1;
	logic [PIN_W-1:0] pa_s2;
	logic [PIN_W-1:0] pb_s1;
	logic [PIN_W-1:0] pb_s2;
	logic [PIN_W-1:0] pc_s1;
	logic [PIN_W-1:0] pc_s2;

	logic [NUM_BLOCKS-1:0] sel_n_s;
	logic [1:0]            addr_s;
	logic                  read_n_s;
	logic                  write_n_s;
	logic                  rw_s;

	logic [NUM_BLOCKS-1:0] rd_act;
	logic [NUM_BLOCKS-1:0] wr_act;
	logic [NUM_BLOCKS-1:0] wr_act_r;
	logic [NUM_BLOCKS-1:0] wr_pulse;
	logic [1:0]            wr_addr_r [NUM_BLOCKS];
	logic [DATA_W-1:0]     wr_data_r [NUM_BLOCKS];
	logic [DATA_W-1:0]     blk_rdata [NUM_BLOCKS];

	logic [DATA_W-1:0] dev_data_r;
	logic [DATA_W-1:0] dev_data_nxt;
	logic              dev_oe_r;
	logic              dev_oe_nxt;

	assign ctl_raw = {
		bus.block1_select_n,
		bus.block0_select_n,
		bus.port_selector_msb,
		bus.port_selector_lsb,
		bus.read_n,
		bus.write_n,
		bus.rw_dir
	};
	assign strap_raw = {block1_reset_state_strap, block0_reset_state_strap};

	// all pins are asynchronous to clk: two flops before any use
	always_ff @(posedge clk)
	begin
		ctl_s1 <= ctl_raw;
		ctl_s2 <= ctl_s1;
	end

	always_ff @(posedge clk)
	begin
		data_s1 <= bus.data_bus;
		data_s2 <= data_s1;
	end

	// strap kept synchronised during reset so its release sees it
	always_ff @(posedge clk)
	begin
		strap_s1 <= strap_raw;
		strap_s2 <= strap_s1;
	end

	always_ff @(posedge clk)
	begin
		pa_s1 <= pa_in;
		pa_s2 <= pa_s1;
		pb_s1 <= pb_in;
		pb_s2 <= pb_s1;
		pc_s1 <= pc_in;
		pc_s2 <= pc_s1;
	end

	assign sel_n_s   = ctl_s2[6:5];
	assign addr_s    = ctl_s2[4:3];
	assign read_n_s  = ctl_s2[2];
	assign write_n_s = ctl_s2[1];
	assign rw_s      = ctl_s2[0];

	// strobe decode per block; a high select masks every strobe
	always_comb
	begin
		for (int b = 0; b < NUM_BLOCKS; b++)
		begin
			if (sel_n_s[b])
			begin
				rd_act[b] = 1'b0;
				wr_act[b] = 1'b0;
			end
			else if (SEPARATE_STROBES)
			begin
				rd_act[b] = !read_n_s;
				wr_act[b] = !write_n_s;
			end
			else
			begin
				rd_act[b] = rw_s;
				wr_act[b] = !rw_s;
			end
		end
	end

	// address and data tracked while the write strobe is active
	always_ff @(posedge clk)
	begin
		for (int b = 0; b < NUM_BLOCKS; b++)
		begin
			if (reset)
			begin
				wr_addr_r[b] <= SEL_PA;
				wr_data_r[b] <= LATCH_RESET;
			end
			else if (wr_act[b])
			begin
				wr_addr_r[b] <= addr_s;
				wr_data_r[b] <= data_s2;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			wr_act_r <= '0;
		else
			wr_act_r <= wr_act;
	end

	// commit once, on the falling edge of the write activity
	assign wr_pulse = wr_act_r & ~wr_act;

	for (genvar g = 0; g < NUM_BLOCKS; g++)
	begin : g_blk
		dppi_block u_blk (
			.clk      (clk),
			.reset    (reset),
			.strap_s  (strap_s2[g]),
			.wr_pulse (wr_pulse[g]),
			.wr_addr  (wr_addr_r[g]),
			.wr_data  (wr_data_r[g]),
			.rd_addr  (addr_s),
			.pa_in    (pa_s2[g*DATA_W +: DATA_W]),
			.pb_in    (pb_s2[g*DATA_W +: DATA_W]),
			.pc_in    (pc_s2[g*DATA_W +: DATA_W]),
			.rdata    (blk_rdata[g]),
			.pa_out   (pa_out[g]),
			.pa_oe    (pa_oe[g]),
			.pb_out   (pb_out[g]),
			.pb_oe    (pb_oe[g]),
			.pc_out   (pc_out[g]),
			.pc_oe    (pc_oe[g])
		);
	end

	// block 0 wins if the host wrongly selects both for a read
	always_comb
	begin
		dev_oe_nxt   = 1'b0;
		dev_data_nxt = dev_data_r;
		if (addr_s != SEL_CTRL)
		begin
			if (rd_act[0])
			begin
				dev_oe_nxt   = 1'b1;
				dev_data_nxt = blk_rdata[0];
			end
			else if (rd_act[1])
			begin
				dev_oe_nxt   = 1'b1;
				dev_data_nxt = blk_rdata[1];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			dev_oe_r <= 1'b0;
		else
			dev_oe_r <= dev_oe_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			dev_data_r <= LATCH_RESET;
		else
			dev_data_r <= dev_data_nxt;
	end

	assign bus.dev_data    = dev_data_r;
	assign bus.dev_data_oe = dev_oe_r;
endmodule

// ==== logic/dppi_host.sv ====
// host end: turns one command into a timed select/strobe bus cycle
module dppi_host
	import dppi_pkg::*;
#(
	parameter bit SEPARATE_STROBES = 1'b1,
	parameter int SETUP_N          = SETUP_CYC,
	parameter int STROBE_N         = STROBE_CYC,
	parameter int HOLD_N           = HOLD_CYC
)
(
	input  wire logic              clk,
	input  wire logic              reset,
	dppi_if.host                   bus,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_write,
	input  wire logic              cmd_block,
	input  wire logic [1:0]        cmd_sel,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_rdata
);
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_SETUP  = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD   = 4'h8
	} dppi_hst_t;

	dppi_hst_t         state_r;
	logic [7:0]        cnt_r;
	logic              write_r;
	logic              block_r;
	logic [1:0]        sel_r;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] rd_s1;
	logic [DATA_W-1:0] rd_s2;
	logic              forbidden;

	assign cmd_ready = state_r == ST_IDLE;
	assign forbidden = !cmd_write && cmd_sel == SEL_CTRL;

	always_ff @(posedge clk)
	begin
		rd_s1 <= bus.data_bus;
		rd_s2 <= rd_s1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					if (cmd_valid && !forbidden)
					begin
						state_r <= ST_SETUP;
						cnt_r   <= 8'(SETUP_N - 1);
					end
				ST_SETUP:
					if (cnt_r == '0)
					begin
						state_r <= ST_STROBE;
						cnt_r   <= 8'(STROBE_N - 1);
					end
					else
						cnt_r <= cnt_r - 8'h01;
				ST_STROBE:
					if (cnt_r == '0)
					begin
						state_r <= ST_HOLD;
						cnt_r   <= 8'(HOLD_N - 1);
					end
					else
						cnt_r <= cnt_r - 8'h01;
				ST_HOLD:
					if (cnt_r == '0)
						state_r <= ST_IDLE;
					else
						cnt_r <= cnt_r - 8'h01;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			write_r <= 1'b0;
			block_r <= 1'b0;
			sel_r   <= SEL_PA;
			wdata_r <= LATCH_RESET;
		end
		else if (cmd_ready && cmd_valid)
		begin
			write_r <= cmd_write;
			block_r <= cmd_block;
			sel_r   <= cmd_sel;
			wdata_r <= cmd_wdata;
		end
	end

	// forbidden read answers at once with idle bus, no bus cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= BUS_IDLE;
		end
		else if (cmd_ready && cmd_valid && forbidden)
		begin
			rsp_valid <= 1'b1;
			rsp_rdata <= BUS_IDLE;
		end
		else if (state_r == ST_STROBE && cnt_r == '0 && !write_r)
		begin
			rsp_valid <= 1'b1;
			rsp_rdata <= rd_s2;
		end
		else
			rsp_valid <= 1'b0;
	end

	// select low only in the strobe phase; address held around it
	assign bus.block0_select_n   = !(state_r == ST_STROBE && !block_r);
	assign bus.block1_select_n   = !(state_r == ST_STROBE && block_r);
	assign bus.port_selector_lsb = sel_r[0];
	assign bus.port_selector_msb = sel_r[1];
	assign bus.read_n  = !(SEPARATE_STROBES && state_r == ST_STROBE
		&& !write_r);
	assign bus.write_n = !(SEPARATE_STROBES && state_r == ST_STROBE
		&& write_r);
	assign bus.rw_dir  = state_r == ST_IDLE || !write_r;
	assign bus.host_data    = wdata_r;
	assign bus.host_data_oe = write_r && state_r != ST_IDLE;
endmodule

// ==== testbench/dppi_props.sv ====
// concurrent checks on the pin bus joining the two ends
module dppi_props
(
	input wire logic clk,
	input wire logic reset,
	input wire logic block0_select_n,
	input wire logic block1_select_n,
	input wire logic port_selector_lsb,
	input wire logic port_selector_msb,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic dev_data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] sel;
	logic       none;
	assign sel = {port_selector_msb, port_selector_lsb};
	assign none = block0_select_n && block1_select_n;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_RESET_QUIET: assert property (disable iff (1'b0)
		reset ##1 reset |-> !dev_data_oe && none)
		else $error("bus active during reset");
	// four cycles covers the two-flop lag plus the drop
	AST_DESEL_RELEASE: assert property (none [*4] |-> !dev_data_oe)
		else $error("bus driven while deselected");
	AST_RD_DRIVE: assert property (
		(!none && !read_n && sel != 2'h3) [*5] |-> dev_data_oe)
		else $error("read not driven");
	AST_NO_CTRL_READ: assert property (sel == 2'h3 [*4] |-> !dev_data_oe)
		else $error("control value driven");
	AST_WR_NO_DRIVE: assert property (!write_n [*4] |-> !dev_data_oe)
		else $error("bus driven during write");
	AST_STROBE_IN_SELECT: assert property (
		!(write_n && read_n) |-> !none)
		else $error("strobe outside select");
	AST_SELECT_HOLD: assert property (
		$rose(write_n) |-> $stable(sel) [*2])
		else $error("selector moved after write");
	AST_STROBE_LEN: assert property (
		$fell(write_n) |-> !write_n [*8] ##1 write_n)
		else $error("write strobe length wrong");
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench: both ends on two buses, strobes and direction line
module testbench
	import dppi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [NUM_BLOCKS-1:0][DATA_W-1:0] dppi_vec_t;
	logic       clk;
	logic       reset;
	logic       cmd_valid;
	logic       cmd_write;
	logic       cmd_block;
	logic [1:0] cmd_sel;
	logic [7:0] cmd_wdata;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_rdata;
	logic       rsp_valid_dir;
	logic [7:0] rsp_rdata_dir;
	logic [7:0] rd;
	logic [7:0] rd2;
	logic       strap0;
	logic       strap1;
	dppi_vec_t  pa_in;
	dppi_vec_t  pb_in;
	dppi_vec_t  pc_in;
	dppi_vec_t  pa_out;
	dppi_vec_t  pa_oe;
	dppi_vec_t  pb_out;
	dppi_vec_t  pb_oe;
	dppi_vec_t  pc_out;
	dppi_vec_t  pc_oe;
	int         n_errors;
	int         compares;

	dppi_if bus ();
	dppi_if bus_dir ();
	dppi_host #(.SEPARATE_STROBES(1'b1)) u_dppi_host (.clk(clk),
		.reset(reset), .bus(bus), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_block(cmd_block),
		.cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata));
	dppi_device #(.SEPARATE_STROBES(1'b1)) u_dppi_device (.clk(clk),
		.reset(reset), .bus(bus), .block0_reset_state_strap(strap0),
		.block1_reset_state_strap(strap1), .pa_in(pa_in), .pb_in(pb_in),
		.pc_in(pc_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
		.pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe));
	// direction-line pair runs in lockstep, judged by its read answers
	dppi_host #(.SEPARATE_STROBES(1'b0)) u_dppi_host_dir (.clk(clk),
		.reset(reset), .bus(bus_dir), .cmd_valid(cmd_valid),
		.cmd_ready(), .cmd_write(cmd_write), .cmd_block(cmd_block),
		.cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid_dir), .rsp_rdata(rsp_rdata_dir));
	dppi_device #(.SEPARATE_STROBES(1'b0)) u_dppi_device_dir (.clk(clk),
		.reset(reset), .bus(bus_dir), .block0_reset_state_strap(strap0),
		.block1_reset_state_strap(strap1), .pa_in(pa_in), .pb_in(pb_in),
		.pc_in(pc_in), .pa_out(), .pa_oe(), .pb_out(), .pb_oe(),
		.pc_out(), .pc_oe());
	dppi_props u_dppi_props (.clk(clk), .reset(reset),
		.block0_select_n(bus.block0_select_n),
		.block1_select_n(bus.block1_select_n),
		.port_selector_lsb(bus.port_selector_lsb),
		.port_selector_msb(bus.port_selector_msb),
		.read_n(bus.read_n), .write_n(bus.write_n),
		.dev_data_oe(bus.dev_data_oe));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one command on both pairs; answers left in rd and rd2
	task automatic xfer(input logic w, input logic b, input logic [1:0] s,
		input logic [7:0] d);
		int n;
		rd = 8'hXX;
		rd2 = 8'hXX;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_block = b;
		cmd_sel = s;
		cmd_wdata = d;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
			@(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		for (n = 0; n < 40; n++)
		begin
			if (rsp_valid === 1'b1)
				rd = rsp_rdata;
			if (rsp_valid_dir === 1'b1)
				rd2 = rsp_rdata_dir;
			if (cmd_ready === 1'b1)
				break;
			@(negedge clk);
		end
	endtask

	task automatic t_reset_state(input logic s0, input logic s1);
		logic [7:0] oe;
		@(negedge clk);
		strap0 = s0;
		strap1 = s1;
		reset = 1'b1;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		for (int b = 0; b < 2; b++)
		begin
			oe = ((b == 0) ? s0 : s1) ? 8'h00 : 8'hFF;
			check(pa_oe[b], oe);
			check(pb_oe[b], oe);
			check(pc_oe[b], oe);
			check(pa_out[b] | pb_out[b] | pc_out[b], 8'h00);
		end
		$display("reset state test done");
	endtask

	task automatic t_read_inputs(input logic b);
		dppi_vec_t v;
		for (int s = 0; s < 3; s++)
		begin
			v = (s == 0) ? pa_in : ((s == 1) ? pb_in : pc_in);
			xfer(1'b0, b, s[1:0], 8'h00);
			check(rd, v[b]);
			check(rd2, v[b]);
		end
		$display("input read test done");
	endtask

	task automatic t_ctrl_read;
		xfer(1'b0, 1'b0, SEL_CTRL, 8'h00);
		check(rd, BUS_IDLE);
		check(rd2, BUS_IDLE);
		$display("control read test done");
	endtask

	task automatic t_write_ports;
		xfer(1'b1, 1'b0, SEL_CTRL, CTRL_ALL_OUT);
		xfer(1'b1, 1'b0, SEL_PA, 8'h5A);
		xfer(1'b1, 1'b0, SEL_PB, 8'hA5);
		xfer(1'b1, 1'b0, SEL_PC, 8'h3C);
		repeat (4) @(negedge clk);
		check(pa_oe[0] & pb_oe[0] & pc_oe[0], 8'hFF);
		check(pa_out[0], 8'h5A);
		check(pb_out[0], 8'hA5);
		check(pc_out[0], 8'h3C);
		check(pa_out[1] | pb_out[1] | pc_out[1], 8'h00);
		xfer(1'b0, 1'b0, SEL_PB, 8'h00);
		check(rd, 8'hA5);
		check(rd2, 8'hA5);
		// control code with mode flag clear: set bit 7 of port C
		xfer(1'b1, 1'b0, SEL_CTRL, 8'h0F);
		xfer(1'b0, 1'b0, SEL_PC, 8'h00);
		check(pc_out[0], 8'hBC);
		check(rd, 8'hBC);
		check(rd2, 8'hBC);
		$display("port write test done");
	endtask

	// strap-high block 1 must not pick up a write aimed at block 0
	task automatic t_deselect;
		xfer(1'b1, 1'b0, SEL_PA, 8'h5A);
		repeat (4) @(negedge clk);
		check(pa_out[1], 8'h00);
		check(pa_oe[1], 8'h00);
		check(pa_out[0], 8'h00);
		check(pa_oe[0], 8'hFF);
		$display("deselect test done");
	endtask

	task automatic t_forced_low;
		xfer(1'b1, 1'b1, SEL_PA, 8'h5A);
		xfer(1'b1, 1'b1, SEL_CTRL, CTRL_ALL_IN);
		repeat (4) @(negedge clk);
		check(pa_oe[1] & pb_oe[1] & pc_oe[1], 8'hFF);
		check(pa_out[1] | pb_out[1] | pc_out[1], 8'h00);
		xfer(1'b0, 1'b1, SEL_PA, 8'h00);
		check(rd, 8'h00);
		check(rd2, 8'h00);
		$display("forced output test done");
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		$display("watchdog expired");
		test_done;
	end

	initial
	begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_block = 1'b0;
		cmd_sel = 2'h0;
		cmd_wdata = 8'h00;
		strap0 = 1'b1;
		strap1 = 1'b0;
		pa_in = {8'h96, 8'h69};
		pb_in = {8'h4B, 8'hB4};
		pc_in = {8'hE1, 8'h1E};
		n_errors = 0;
		compares = 0;
		t_reset_state(1'b1, 1'b0);
		t_read_inputs(1'b0);
		t_ctrl_read;
		t_write_ports;
		t_forced_low;
		t_reset_state(1'b0, 1'b1);
		t_deselect;
		t_read_inputs(1'b1);
		test_done;
	end
endmodule
